/* File: pmd_params.svh */
// Constants for the paged memory decode block: offsets, fields, reset values and address ranges.
//
// Behaviour
// - Core reads and writes the page register at run time; it steers the map.
// - Only page register bits 0 to 2 feed the decode array; none feeds the logic array.
// - N paging bits select among two to the power N pages.
// - Paging bits start at page bit 0 and extend the core address upward.
// - Bits above the paging bits start at page bit 3 and feed no logic array term.
// - Page bits 0 to 2 page eight pages; bits 3 to 7 stay unused.
// - Decode array asserts one select per flash, boot, SRAM and control segment.
// - After power-up secondary flash answers data reads and writes only.
// - Port A repeats core data only while the peripheral range is active.
// - Port B bits 1 and 2 are logic array outputs, registered before the pins.
// - Port B bits 3 and 4 are active-high external chip selects.
`ifndef PMD_PARAMS_SVH
`define PMD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------------
`define PMD_PAGE_OFS     12'h000
`define PMD_CTRL_OFS     12'h004
`define PMD_STAT_OFS     12'h008
`define PMD_PAGE_RST     8'h00
`define PMD_CTRL_RST     1'b1
`define PMD_CTRL_PA_EN   0
`define PMD_PAGE_BITS    3

// ----------------------------------------------------------------------------
// Core address ranges
// ----------------------------------------------------------------------------
`define PMD_FS0_HI       16'h7fff
`define PMD_SRAM_LO      16'h2000
`define PMD_SRAM_HI      16'h3fff
`define PMD_IOP_LO       16'h0200
`define PMD_IOP_HI       16'h02ff
`define PMD_PERI_LO      16'h0400
`define PMD_PERI_HI      16'h04ff
`define PMD_EXT1_LO      16'h7fd0
`define PMD_EXT1_HI      16'h7fd1
`define PMD_EXT2_LO      16'h7fd2
`define PMD_EXT2_HI      16'h7fd3

`endif

/* File: pmd_pkg.sv */
// Types shared by the paged memory decode block.
`default_nettype none
package pmd_pkg;
    // Kind of core bus cycle presented to the decode array.
    typedef enum logic [1:0] {
        PMD_ACC_IDLE,
        PMD_ACC_CODE,
        PMD_ACC_DATA
    } pmd_acc_t;

    // One select per memory segment, plus the external selects.
    typedef struct packed {
        logic [7:0] fs;
        logic [3:0] boot;
        logic       sram;
        logic       iop;
        logic       peri;
        logic       ext1;
        logic       ext2;
    } pmd_sel_t;
endpackage
`default_nettype wire

/* File: pmd_seg_decode.sv */
// Address decode array: core address plus page bits to segment selects.
`include "pmd_params.svh"
`default_nettype none
module pmd_seg_decode
    import pmd_pkg::*;
(
    input  wire logic [15:0] addr,  // Core address.
    input  wire logic [7:0]  page,  // All page register bits.
    input  wire pmd_acc_t    acc,   // Cycle kind.
    output pmd_sel_t         sel    // Segment selects.
);
    logic [`PMD_PAGE_BITS-1:0] pg;
    logic                      dat;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    // Only the low paging bits join the flash decode; upper bits go unused.
    always_comb begin
        pg  = page[`PMD_PAGE_BITS-1:0];
        dat = (acc == PMD_ACC_DATA);
        sel = '0;
        if (acc == PMD_ACC_CODE) begin
            if (addr <= `PMD_FS0_HI) begin
                sel.fs[0] = 1'b1;
            end else if (pg != '0) begin
                sel.fs[pg] = 1'b1;
            end
        end
        if (dat && addr[15]) begin
            sel.boot[addr[14:13]] = 1'b1;
        end
        sel.sram = dat && addr >= `PMD_SRAM_LO && addr <= `PMD_SRAM_HI;
        sel.iop  = dat && addr >= `PMD_IOP_LO && addr <= `PMD_IOP_HI;
        sel.peri = dat && addr >= `PMD_PERI_LO && addr <= `PMD_PERI_HI;
        sel.ext1 = dat && addr >= `PMD_EXT1_LO && addr <= `PMD_EXT1_HI;
        sel.ext2 = dat && addr >= `PMD_EXT2_LO && addr <= `PMD_EXT2_HI;
    end
endmodule
`default_nettype wire

/* File: pmd_top.sv */
// Page register, APB access, decode and port logic of the paged memory decode block.
`include "pmd_params.svh"
`default_nettype none
module pmd_top
    import pmd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,                            // Clock, 25 MHz.
    input  wire logic              presetn,                         // Async reset, low.
    input  wire logic              psel,                            // APB select.
    input  wire logic              penable,                         // APB enable.
    input  wire logic              pwrite,                          // APB direction.
    input  wire logic [ADDR_W-1:0] paddr,                           // APB byte address.
    input  wire logic [31:0]       pwdata,                          // APB write data.
    output logic [31:0]            prdata,                          // APB read data.
    output logic                   pready,                          // APB ready.
    output logic                   pslverr,                         // APB error.
    input  wire logic [15:0]       core_addr,                       // Core address.
    input  wire logic              core_fetch,                      // Code fetch strobe.
    input  wire logic              core_rd,                         // Data read strobe.
    input  wire logic              core_wr,                         // Data write strobe.
    input  wire logic [7:0]        core_wdata,                      // Core write data.
    output logic [7:0]             core_rdata,                      // Repeated read data.
    output logic [7:0]             main_flash_segment_select,       // Main flash selects.
    output logic [3:0]             secondary_flash_segment_select,  // Boot flash selects.
    output logic                   sram_segment_select,             // SRAM select.
    output logic                   iop_segment_select,              // Control block select.
    output logic                   periph_select,                   // Peripheral range.
    input  wire logic [7:0]        pa_in,                           // Port A pins in.
    output logic [7:0]             pa_out,                          // Port A pins out.
    output logic                   pa_oe,                           // Port A drive enable.
    output logic [4:1]             pb_out                           // Port B bits 1 to 4.
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0]  page_q;
    logic [7:0]  page_d;
    logic        ctrl_q;
    logic        ctrl_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        wr_en;
    logic        setup;
    logic        mapped;
    pmd_acc_t    acc;
    pmd_sel_t    dec;
    pmd_sel_t    sel_q;
    pmd_sel_t    sel_d;
    logic [7:0]  pa_meta_q;
    logic [7:0]  pa_sync_q;
    logic [7:0]  pa_out_q;
    logic [7:0]  pa_out_d;
    logic        pa_oe_q;
    logic        pa_oe_d;
    logic [7:0]  crd_q;
    logic [7:0]  crd_d;
    logic [4:1]  pb_q;
    logic [4:1]  pb_d;

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // Answers in the access phase with no wait state; data is prepared at setup.
    always_comb begin
        setup  = psel && !penable;
        wr_en  = psel && penable && pready_q && pwrite;
        mapped = paddr == `PMD_PAGE_OFS || paddr == `PMD_CTRL_OFS ||
                 paddr == `PMD_STAT_OFS;
        pready_d  = setup;
        pslverr_d = setup && !mapped;
        prdata_d  = '0;
        if (setup && !pwrite) begin
            case (paddr)
                `PMD_PAGE_OFS: prdata_d[7:0] = page_q;
                `PMD_CTRL_OFS: prdata_d[0]   = ctrl_q;
                `PMD_STAT_OFS: prdata_d[16:0] = sel_q;
                default:       prdata_d      = '0;
            endcase
        end
    end

    // Registers of the bus answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Page and control registers
    // ------------------------------------------------------------------------
    // A write lands only at the access edge that sees pready high.
    always_comb begin
        page_d = page_q;
        ctrl_d = ctrl_q;
        if (wr_en && paddr == `PMD_PAGE_OFS) begin
            page_d = pwdata[7:0];
        end
        if (wr_en && paddr == `PMD_CTRL_OFS) begin
            ctrl_d = pwdata[`PMD_CTRL_PA_EN];
        end
    end

    // Page 0 is in force until software picks another.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= `PMD_PAGE_RST;
            ctrl_q <= `PMD_CTRL_RST;
        end else begin
            page_q <= page_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------------
    // Address decode array
    // ------------------------------------------------------------------------
    // A fetch wins over a data strobe should both be raised together.
    always_comb begin
        if (core_fetch) begin
            acc = PMD_ACC_CODE;
        end else if (core_rd || core_wr) begin
            acc = PMD_ACC_DATA;
        end else begin
            acc = PMD_ACC_IDLE;
        end
        sel_d = dec;
    end

    pmd_seg_decode u_dec (
        .addr (core_addr),
        .page (page_q),
        .acc  (acc),
        .sel  (dec)
    );

    // Selects are registered so outputs come from flops; one cycle late.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------------------
    // Port A peripheral repeater
    // ------------------------------------------------------------------------
    // Pins come from outside the clock domain, so two flops precede any use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_meta_q <= 8'h00;
            pa_sync_q <= 8'h00;
        end else begin
            pa_meta_q <= pa_in;
            pa_sync_q <= pa_meta_q;
        end
    end

    // Data passes only inside the peripheral range and only if enabled.
    always_comb begin
        pa_oe_d  = dec.peri && core_wr && ctrl_q;
        pa_out_d = pa_oe_d ? core_wdata : 8'h00;
        crd_d    = (dec.peri && core_rd && ctrl_q) ? pa_sync_q : 8'h00;
    end

    // Port A state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_oe_q  <= 1'b0;
            pa_out_q <= 8'h00;
            crd_q    <= 8'h00;
        end else begin
            pa_oe_q  <= pa_oe_d;
            pa_out_q <= pa_out_d;
            crd_q    <= crd_d;
        end
    end

    // ------------------------------------------------------------------------
    // Logic array and Port B
    // ------------------------------------------------------------------------
    // Bit 1 flags a read of the external module, bit 2 repeats address bit 0 during an external access.
    // Page bits 3 to 7 do not reach this array and no term uses them here.
    always_comb begin
        pb_d[1] = (dec.ext1 || dec.ext2) && core_rd;
        pb_d[2] = (dec.ext1 || dec.ext2) && core_addr[0];
        pb_d[3] = dec.ext1;
        pb_d[4] = dec.ext2;
    end

    // Port B state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb_q <= 4'h0;
        end else begin
            pb_q <= pb_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata                         = prdata_q;
    assign pready                         = pready_q;
    assign pslverr                        = pslverr_q;
    assign core_rdata                     = crd_q;
    assign main_flash_segment_select      = sel_q.fs;
    assign secondary_flash_segment_select = sel_q.boot;
    assign sram_segment_select            = sel_q.sram;
    assign iop_segment_select             = sel_q.iop;
    assign periph_select                  = sel_q.peri;
    assign pa_out                         = pa_out_q;
    assign pa_oe                          = pa_oe_q;
    assign pb_out                         = pb_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Write then read-back of the page register within two transfers.
    a_page_write: assert property (
        wr_en && paddr == `PMD_PAGE_OFS |=> page_q == $past(pwdata[7:0]))
        else $error("page register did not take the written value");

    a_page_read: assert property (
        setup && !pwrite && paddr == `PMD_PAGE_OFS |=> pready && prdata[7:0] == page_q)
        else $error("page register read returned wrong data");

    a_page_hold: assert property (
        !(wr_en && paddr == `PMD_PAGE_OFS) |=> $stable(page_q))
        else $error("page register changed without a write");

    a_page_fs: assert property (
        core_fetch && core_addr[15] && page_q[2:0] != 3'h0
        |=> main_flash_segment_select == 8'h01 << $past(page_q[2:0]))
        else $error("paged flash select does not follow page bits");

    a_fs_code: assert property (
        main_flash_segment_select != 8'h00 |-> $past(core_fetch))
        else $error("main flash selected outside a code fetch");

    a_boot_data: assert property (
        secondary_flash_segment_select != 4'h0
        |-> !$past(core_fetch) && $past(core_rd || core_wr))
        else $error("secondary flash selected outside a data cycle");

    a_sel_onehot: assert property ($onehot0(sel_q))
        else $error("more than one segment selected");

    a_pa_repeat: assert property (
        pa_oe |-> $past(core_wr) && periph_select && $past(ctrl_q))
        else $error("port A driven outside the peripheral range");

    a_ext_cs: assert property (
        core_rd && core_addr == `PMD_EXT1_LO && !core_fetch
        |=> pb_out[3] && pb_out[1] && !pb_out[4])
        else $error("external select or logic output wrong");

    a_pb_logic: assert property (
        pb_out[2] |-> $past(core_addr[0]) && (pb_out[3] || pb_out[4]))
        else $error("port B bit 2 without external access");

    // Bus answer: one ready pulse per setup, an error only off the map, data only with ready.
    a_ready_setup: assert property (
        psel && !penable |=> pready)
        else $error("no ready after setup");

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");

    a_err_unmapped: assert property (
        psel && !penable && !(paddr == `PMD_PAGE_OFS || paddr == `PMD_CTRL_OFS || paddr == `PMD_STAT_OFS)
        |=> pslverr)
        else $error("unmapped address not refused");

    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the access cycle");

    a_ctrl_write: assert property (
        wr_en && paddr == `PMD_CTRL_OFS |=> ctrl_q == $past(pwdata[`PMD_CTRL_PA_EN]))
        else $error("control register did not take the write");

    // The map restarts on page 0 after every reset, a mid-run one too.
    a_page_reset: assert property ($rose(presetn) |-> page_q == `PMD_PAGE_RST)
        else $error("page not cleared by reset");

    // Selects follow the address map one edge after the core cycle.
    a_fs0_fetch: assert property (
        core_fetch && !core_addr[15] |=> main_flash_segment_select == 8'h01)
        else $error("low code fetch missed main flash segment 0");

    a_page_zero: assert property (
        core_fetch && core_addr[15] && page_q[2:0] == 3'h0 |=> main_flash_segment_select == 8'h00)
        else $error("upper fetch on page 0 selected flash");

    a_boot_hit: assert property (
        (core_rd || core_wr) && !core_fetch && core_addr[15]
        |=> secondary_flash_segment_select == 4'h1 << $past(core_addr[14:13]))
        else $error("data access missed its secondary segment");

    a_sram_hit: assert property (
        (core_rd || core_wr) && !core_fetch && core_addr >= `PMD_SRAM_LO && core_addr <= `PMD_SRAM_HI
        |=> sram_segment_select)
        else $error("SRAM access not selected");

    a_sram_only: assert property (
        sram_segment_select |-> !$past(core_fetch) &&
        $past(core_addr) >= `PMD_SRAM_LO && $past(core_addr) <= `PMD_SRAM_HI)
        else $error("SRAM selected outside its range");

    // Port A repeats only what the core wrote; port B bit 1 only flags external reads.
    a_pa_data: assert property (pa_oe |-> pa_out == $past(core_wdata))
        else $error("port A does not repeat core data");

    a_pa_idle: assert property (!pa_oe |-> pa_out == 8'h00)
        else $error("port A data without drive enable");

    a_rdata_gate: assert property (
        core_rdata != 8'h00 |-> periph_select && $past(core_rd))
        else $error("port A read data outside the peripheral range");

    a_pb_read: assert property (
        pb_out[1] |-> $past(core_rd) && (pb_out[3] || pb_out[4]))
        else $error("port B bit 1 without external read");

    c_paged_fetch: cover property (core_fetch && core_addr[15] && page_q == 8'h07);
    c_boot_write:  cover property (core_wr && core_addr[15] ##1 secondary_flash_segment_select[3]);
    c_pa_write:    cover property (pa_oe ##1 !pa_oe);
    c_apb_error:   cover property (pslverr && pready);
    c_page_read:   cover property (pready && !pslverr && prdata[7:0] == 8'h5a);
endmodule
`default_nettype wire

/* File: pmd_core_model.sv */
// Behavioural core model: APB master for the registers and driver of the core bus.
`default_nettype none
module pmd_core_model #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,       // Core clock.
    output logic                   psel,       // APB select.
    output logic                   penable,    // APB enable.
    output logic                   pwrite,     // APB direction.
    output logic [ADDR_W-1:0]      paddr,      // APB address.
    output logic [31:0]            pwdata,     // APB write data.
    input  wire logic [31:0]       prdata,     // APB read data.
    input  wire logic              pready,     // APB ready.
    input  wire logic              pslverr,    // APB error.
    output logic [15:0]            core_addr,  // Core address.
    output logic                   core_fetch, // Code fetch strobe.
    output logic                   core_rd,    // Data read strobe.
    output logic                   core_wr,    // Data write strobe.
    output logic [7:0]             core_wdata  // Core write data.
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Idle state at time zero
    // ------------------------------------------------------------
    // Everything starts low so nothing is requested during reset.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {core_addr, core_fetch, core_rd, core_wr, core_wdata} = '0;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // One APB transfer; it opens with an edge so two calls never collide.
    task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] adr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show junk, so a slave cannot lean on stale values.
        paddr <= ~adr;
        pwdata <= ~wd;
    endtask

    // Core cycle: kind 0 idle, 1 fetch, 2 data read, 3 data write; held until the next call.
    task automatic core_drive(input logic [1:0] kind, input logic [15:0] adr, input logic [7:0] wd);
        @(posedge pclk);
        core_fetch <= (kind == 2'd1);
        core_rd <= (kind == 2'd2);
        core_wr <= (kind == 2'd3);
        core_addr <= adr;
        core_wdata <= wd;
    endtask
endmodule
`default_nettype wire

/* File: test_paged_memory_decode.sv */
// Self-checking testbench of the paged memory decode block.
`include "pmd_params.svh"
`default_nettype none
module test_paged_memory_decode;
    import pmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  kind;
        logic [15:0] addr;
        logic [7:0]  page;
        logic [7:0]  fs;
        logic [3:0]  boot;
        logic [2:0]  mem;  // Sram, control block, peripheral.
        logic [4:1]  pb;
    } pmd_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        core_fetch, core_rd, core_wr, sram, iop, peri, pa_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] core_addr;
    logic [7:0]  core_wdata, core_rdata, fs, pa_in, pa_out;
    logic [3:0]  boot;
    logic [4:1]  pb;
    logic        err;
    int          errors, total_checks;
    pmd_row_t    rows [16] = '{
        '{2'd1, 16'h0000, 8'h00, 8'h01, 4'h0, 3'h0, 4'h0},
        '{2'd1, 16'h9000, 8'h03, 8'h08, 4'h0, 3'h0, 4'h0},
        '{2'd1, 16'h8000, 8'h07, 8'h80, 4'h0, 3'h0, 4'h0},
        '{2'd1, 16'hffff, 8'h01, 8'h02, 4'h0, 3'h0, 4'h0},
        '{2'd1, 16'h8000, 8'h00, 8'h00, 4'h0, 3'h0, 4'h0},
        '{2'd1, 16'h9000, 8'h0b, 8'h08, 4'h0, 3'h0, 4'h0},
        '{2'd2, 16'h8000, 8'h00, 8'h00, 4'h1, 3'h0, 4'h0},
        '{2'd3, 16'he000, 8'h05, 8'h00, 4'h8, 3'h0, 4'h0},
        '{2'd2, 16'ha000, 8'h00, 8'h00, 4'h2, 3'h0, 4'h0},
        '{2'd1, 16'h2000, 8'h00, 8'h01, 4'h0, 3'h0, 4'h0},
        '{2'd2, 16'h3fff, 8'h00, 8'h00, 4'h0, 3'h4, 4'h0},
        '{2'd3, 16'h0200, 8'h00, 8'h00, 4'h0, 3'h2, 4'h0},
        '{2'd2, 16'h04ff, 8'h00, 8'h00, 4'h0, 3'h1, 4'h0},
        '{2'd2, 16'h7fd1, 8'h00, 8'h00, 4'h0, 3'h0, 4'h7},
        '{2'd3, 16'h7fd2, 8'h00, 8'h00, 4'h0, 3'h0, 4'h8},
        '{2'd0, 16'h3000, 8'h00, 8'h00, 4'h0, 3'h0, 4'h0}};

    pmd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_addr(core_addr), .core_fetch(core_fetch), .core_rd(core_rd), .core_wr(core_wr),
        .core_wdata(core_wdata), .core_rdata(core_rdata), .main_flash_segment_select(fs),
        .secondary_flash_segment_select(boot), .sram_segment_select(sram), .iop_segment_select(iop),
        .periph_select(peri), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb));
    pmd_core_model core_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_addr(core_addr), .core_fetch(core_fetch), .core_rd(core_rd), .core_wr(core_wr),
        .core_wdata(core_wdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Selects answer one edge after the core cycle is launched.
    task automatic core_step(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        core_u.core_drive(k, a, d);
        @(posedge pclk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Clock of 40 ns period.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Watchdog: the whole run needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        pa_in = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        core_u.apb_xfer(1'b0, `PMD_PAGE_OFS, 32'h0, rd, err);
        check("page after reset", 32'h0, rd);
        core_u.apb_xfer(1'b0, `PMD_CTRL_OFS, 32'h0, rd, err);
        check("ctrl after reset", 32'h1, rd);
        check("selects after reset", 32'h0, {fs, boot, sram, iop, peri, pb});
        // Table of decode cases, each with its own page value.
        foreach (rows[i]) begin
            core_u.apb_xfer(1'b1, `PMD_PAGE_OFS, {24'hffffff, rows[i].page}, rd, err);
            core_step(rows[i].kind, rows[i].addr, 8'h00);
            check("fs", rows[i].fs, fs);
            check("boot", rows[i].boot, boot);
            check("sram iop peri", rows[i].mem, {sram, iop, peri});
            check("port b", rows[i].pb, pb);
        end
        // Read back all eight page bits; upper word bits read zero.
        core_u.apb_xfer(1'b1, `PMD_PAGE_OFS, 32'hffffff5a, rd, err);
        core_u.apb_xfer(1'b0, `PMD_PAGE_OFS, 32'h0, rd, err);
        check("page readback", 32'h5a, rd);
        // Unmapped address is refused and leaves the page alone.
        core_u.apb_xfer(1'b1, 12'h00c, 32'h1, rd, err);
        check("unmapped write err", 32'h1, err);
        core_u.apb_xfer(1'b0, 12'h00c, 32'h0, rd, err);
        check("unmapped read", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        // Page 0x5a pages to fs2, seen through status bits 16:9.
        core_step(2'd1, 16'h9000, 8'h00);
        core_u.apb_xfer(1'b0, `PMD_STAT_OFS, 32'h0, rd, err);
        check("status fs2", 32'h800, rd);
        // Port A repeats writes only inside the peripheral range.
        core_step(2'd3, 16'h0400, 8'hc3);
        check("pa drive", 32'h1c3, {pa_oe, pa_out});
        core_step(2'd3, 16'h0500, 8'hc3);
        check("pa off range", 32'h0, pa_oe);
        core_u.apb_xfer(1'b1, `PMD_CTRL_OFS, 32'h0, rd, err);
        core_step(2'd3, 16'h0400, 8'h3c);
        check("pa disabled", 32'h0, pa_oe);
        // The enable gates reads as well, so the repeater is switched back on first.
        core_u.apb_xfer(1'b1, `PMD_CTRL_OFS, 32'h1, rd, err);
        pa_in <= 8'h96;
        core_step(2'd2, 16'h0410, 8'h00);
        repeat (4) @(posedge pclk);
        #1;
        check("pa read", 32'h96, core_rdata);
        core_step(2'd2, 16'h3000, 8'h00);
        check("pa read off", 32'h0, core_rdata);
        // Reset in mid-run returns the map to page 0.
        core_u.apb_xfer(1'b1, `PMD_PAGE_OFS, 32'h7, rd, err);
        core_step(2'd1, 16'h9000, 8'h00);
        check("fs page 7", 32'h80, fs);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        check("fs after reset", 32'h0, fs);
        core_u.apb_xfer(1'b0, `PMD_PAGE_OFS, 32'h0, rd, err);
        check("page after reset", 32'h0, rd);
        close_out();
    end
endmodule
`default_nettype wire
